// File: hw/mgmt_access_slave.sv
// MDC/MDIO slave giving full access to the 8-bit configuration space
`timescale 1ns/10ps
module mgmt_access_slave (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic mdc_i,
    input wire logic mdio_i,
    output logic mdio_o,
    output logic mdio_oe_n_o,
    output logic wr_pulse_o,
    output logic [7:0] wr_addr_o,
    output logic [7:0] wr_data_o
);
    logic [1:0] mdc_sync;
    logic [1:0] mdio_sync;
    logic mdc_prev;
    mgmt_access_pkg::state_t state;
    mgmt_access_pkg::state_t next_state;
    logic [5:0] cnt;
    logic [5:0] next_cnt;
    logic [13:0] hdr;
    logic [13:0] next_hdr;
    logic [15:0] shreg;
    logic [15:0] next_shreg;
    logic [7:0] addr;
    logic [7:0] next_addr;
    logic oe_n;
    logic next_oe_n;
    logic dout;
    logic next_dout;
    logic wr_pulse;
    logic next_wr_pulse;
    logic [7:0] wr_data;
    logic [7:0] next_wr_data;
    logic [7:0] rdata;
    logic rise;
    logic fall;
    logic bit_in;
    logic [13:0] hdr_full;

    // Second stage only is read; first stage feeds nothing else
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mdc_sync <= 2'h0;
            mdio_sync <= 2'h3;
            mdc_prev <= 1'b0;
        end else if (ce_i) begin
            mdc_sync <= {mdc_sync[0], mdc_i};
            mdio_sync <= {mdio_sync[0], mdio_i};
            mdc_prev <= mdc_sync[1];
        end
    end

    // MDC at most 5 MHz gives at least two samples per phase at 20 MHz
    assign rise = mdc_sync[1] & ~mdc_prev;
    assign fall = ~mdc_sync[1] & mdc_prev;
    assign bit_in = mdio_sync[1];
    assign hdr_full = {hdr[12:0], bit_in};

    reg_space #(
        .DEPTH(256)
    ) u_space (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .wr_i(next_wr_pulse),
        .addr_i(addr),
        .wdata_i(next_wr_data),
        .rdata_o(rdata)
    );

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_hdr = hdr;
        next_shreg = shreg;
        next_addr = addr;
        next_oe_n = oe_n;
        next_dout = dout;
        next_wr_pulse = 1'b0;
        next_wr_data = wr_data;
        if (rise) begin
            case (state)
                mgmt_access_pkg::ST_PREAMBLE: begin
                    // Count ones; a zero after a full preamble is start bit 0
                    if (bit_in) begin
                        if (cnt != mgmt_access_pkg::PREAMBLE_CNT) begin
                            next_cnt = cnt + 6'h01;
                        end
                    end else if (cnt == mgmt_access_pkg::PREAMBLE_CNT) begin
                        next_state = mgmt_access_pkg::ST_HEADER;
                        next_cnt = 6'h00;
                        next_hdr = 14'h0000;
                    end else begin
                        next_cnt = 6'h00;
                    end
                end
                mgmt_access_pkg::ST_HEADER: begin
                    // Start bit 1, opcode, phy and reg address fields
                    next_hdr = hdr_full;
                    next_cnt = cnt + 6'h01;
                    if (cnt[4:0] == mgmt_access_pkg::FIELD_BITS) begin
                        next_cnt = 6'h00;
                        next_addr = {hdr_full[9:8], hdr_full[5],
                                     hdr_full[4:0]};
                        if (hdr_full[12] && hdr_full[7:6] ==
                                mgmt_access_pkg::PHY_SEL &&
                                (hdr_full[11:10] == mgmt_access_pkg::OP_READ ||
                                 hdr_full[11:10] ==
                                 mgmt_access_pkg::OP_WRITE)) begin
                            next_state = mgmt_access_pkg::ST_TA;
                        end else begin
                            next_state = mgmt_access_pkg::ST_SKIP;
                        end
                    end
                end
                mgmt_access_pkg::ST_TA: begin
                    // First turnaround bit sampled; controller owns it
                    next_cnt = 6'h00;
                    if (hdr[11:10] == mgmt_access_pkg::OP_READ) begin
                        next_shreg = {8'h00, rdata};
                        next_state = mgmt_access_pkg::ST_RD_DATA;
                    end else begin
                        next_state = mgmt_access_pkg::ST_WR_DATA;
                    end
                end
                mgmt_access_pkg::ST_RD_DATA: begin
                    next_cnt = cnt + 6'h01;
                    if (cnt[4:0] == mgmt_access_pkg::DATA_BITS) begin
                        next_state = mgmt_access_pkg::ST_PREAMBLE;
                        next_cnt = 6'h00;
                    end
                end
                mgmt_access_pkg::ST_WR_DATA: begin
                    // Turnaround 0 then sixteen data bits, upper byte dropped
                    next_shreg = {shreg[14:0], bit_in};
                    next_cnt = cnt + 6'h01;
                    if (cnt[4:0] == mgmt_access_pkg::DATA_BITS) begin
                        next_wr_data = {shreg[6:0], bit_in};
                        next_wr_pulse = 1'b1;
                        next_state = mgmt_access_pkg::ST_PREAMBLE;
                        next_cnt = 6'h00;
                    end
                end
                mgmt_access_pkg::ST_SKIP: begin
                    // Frame not ours: sit out turnaround and data
                    next_cnt = cnt + 6'h01;
                    if (cnt[4:0] == mgmt_access_pkg::SKIP_BITS) begin
                        next_state = mgmt_access_pkg::ST_PREAMBLE;
                        next_cnt = 6'h00;
                    end
                end
                default: begin
                    next_state = mgmt_access_pkg::ST_PREAMBLE;
                    next_cnt = 6'h00;
                end
            endcase
        end
        if (fall) begin
            // Drive changes after the falling edge so the master samples stable
            if (state == mgmt_access_pkg::ST_RD_DATA) begin
                if (cnt == 6'h00) begin
                    next_oe_n = 1'b0;
                    next_dout = 1'b0;
                end else begin
                    next_dout = shreg[15];
                    next_shreg = {shreg[14:0], 1'b0};
                end
            end else begin
                next_oe_n = 1'b1;
                next_dout = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state <= mgmt_access_pkg::ST_PREAMBLE;
            cnt <= 6'h00;
            hdr <= 14'h0000;
            shreg <= 16'h0000;
            addr <= 8'h00;
            oe_n <= 1'b1;
            dout <= 1'b0;
            wr_pulse <= 1'b0;
            wr_data <= 8'h00;
        end else if (ce_i) begin
            state <= next_state;
            cnt <= next_cnt;
            hdr <= next_hdr;
            shreg <= next_shreg;
            addr <= next_addr;
            oe_n <= next_oe_n;
            dout <= next_dout;
            wr_pulse <= next_wr_pulse;
            wr_data <= next_wr_data;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wr_addr_o <= 8'h00;
        end else if (ce_i && next_wr_pulse) begin
            wr_addr_o <= addr;
        end
    end

    assign mdio_o = dout;
    assign mdio_oe_n_o = oe_n;
    assign wr_pulse_o = wr_pulse;
    assign wr_data_o = wr_data;
endmodule : mgmt_access_slave

// File: pkg/mgmt_access_pkg.sv
// Constants and types for the full register management access slave
// Operation
// - Frame: preamble, start, op, addresses, turnaround, data
// - Opcode 10 with address bits 2:1 set reads
// - Opcode 01 with address bits 2:1 set writes
// - Target address from phy bits 4,3,0 and reg
// - Read turnaround: controller releases, device drives 0
// - Read returns byte in low bits, zeros above
// - Write stores low byte, ignores upper byte
// - Whole space 0x00-0xFF reachable, indirect registers as plain storage
// - Indirect control 0x6E-0x6F, indirect data 0x70-0x78
// - Per-port factory test bytes 0x15-0x17, step 16
// - Self-test control register sits at 0x88
package mgmt_access_pkg;
    localparam int PREAMBLE_LEN = 32;
    localparam logic [5:0] PREAMBLE_CNT = 6'h20;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] PHY_SEL = 2'h3;
    // Last header count: start bit 1, opcode, both address fields
    localparam logic [4:0] FIELD_BITS = 5'h0c;
    localparam logic [4:0] DATA_BITS = 5'h10;
    // Turnaround plus data bits sat out for a frame not ours
    localparam logic [4:0] SKIP_BITS = 5'h11;
    localparam logic [7:0] IND_CTRL_LO = 8'h6e;
    localparam logic [7:0] IND_CTRL_HI = 8'h6f;
    localparam logic [7:0] IND_DATA_LO = 8'h70;
    localparam logic [7:0] IND_DATA_HI = 8'h78;
    localparam logic [7:0] SELF_TEST_ADDR = 8'h88;
    localparam logic [3:0] FACTORY_LO = 4'h5;
    localparam logic [3:0] FACTORY_HI = 4'h7;
    localparam logic [7:0] REG_RESET = 8'h00;

    typedef enum logic [2:0] {
        ST_PREAMBLE = 3'b000,
        ST_HEADER = 3'b001,
        ST_TA = 3'b010,
        ST_RD_DATA = 3'b011,
        ST_WR_DATA = 3'b100,
        ST_SKIP = 3'b101
    } state_t;
endpackage : mgmt_access_pkg

// File: hw/reg_space.sv
// Configuration byte space with flip-flop storage
`timescale 1ns/10ps
module reg_space #(
    parameter int DEPTH = 256
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic wr_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o
);
    logic [7:0] mem [DEPTH];

    // Every byte 0x00-0xFF is plain storage, indirect and self-test included
    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_byte
            logic [7:0] next_val;
            always_comb begin
                next_val = mem[g];
                if (ce_i && wr_i && addr_i == 8'(g)) begin
                    next_val = wdata_i;
                end
            end
            always_ff @(posedge clk_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    mem[g] <= mgmt_access_pkg::REG_RESET;
                end else begin
                    mem[g] <= next_val;
                end
            end
        end
    endgenerate

    assign rdata_o = mem[addr_i];
endmodule : reg_space

// File: test/mgmt_access_properties.sv
// Port checks for the management access slave
`timescale 1ns/10ps
module mgmt_access_properties (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic mdc_i,
    input wire logic mdio_i,
    input wire logic mdio_o,
    input wire logic mdio_oe_n_o,
    input wire logic wr_pulse_o,
    input wire logic [7:0] wr_addr_o,
    input wire logic [7:0] wr_data_o
);
    logic mdc_q;
    logic [4:0] drv_cnt;
    logic [4:0] next_drv_cnt;
    // Counts management clock rises while the device drives the line
    always_comb begin
        next_drv_cnt = drv_cnt;
        if (mdio_oe_n_o)
            next_drv_cnt = 5'h00;
        else if (mdc_i && !mdc_q)
            next_drv_cnt = drv_cnt + 5'h01;
    end
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mdc_q <= 1'b0;
            drv_cnt <= 5'h00;
        end else begin
            mdc_q <= mdc_i;
            drv_cnt <= next_drv_cnt;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    property p_pulse_one; wr_pulse_o |=> !wr_pulse_o; endproperty
    a_pulse_one: assert property (p_pulse_one)
        else $error("write pulse too long");
    property p_wr_hold; $changed({wr_addr_o, wr_data_o}) |-> wr_pulse_o;
    endproperty
    a_wr_hold: assert property (p_wr_hold)
        else $error("write outputs moved without a write");
    property p_oe_fall; $fell(mdio_oe_n_o) |-> !mdc_i && !mdio_o; endproperty
    a_oe_fall: assert property (p_oe_fall)
        else $error("turnaround drive not a low bit");
    property p_release; $rose(mdio_oe_n_o) |-> !mdc_i; endproperty
    a_release: assert property (p_release)
        else $error("line released in clock high phase");
    property p_count; $rose(mdio_oe_n_o) |-> drv_cnt == 5'h11; endproperty
    a_count: assert property (p_count)
        else $error("driven bit count wrong");
    property p_upper;
        mdc_i && !mdc_q && !mdio_oe_n_o && drv_cnt < 5'h09 |-> !mdio_o;
    endproperty
    a_upper: assert property (p_upper)
        else $error("upper read bits not zero");
    property p_quiet_write; wr_pulse_o |-> mdio_oe_n_o; endproperty
    a_quiet_write: assert property (p_quiet_write)
        else $error("line driven during a write");
    property p_steady; !mdio_oe_n_o && mdc_i |-> $stable(mdio_o); endproperty
    a_steady: assert property (p_steady)
        else $error("read bit changed in clock high phase");
    c_write: cover property (wr_pulse_o);
    c_read: cover property ($rose(mdio_oe_n_o));
    c_turn: cover property ($fell(mdio_oe_n_o));
endmodule : mgmt_access_properties

bind mgmt_access_slave mgmt_access_properties i_props (.clk_i, .sys_rst_i,
    .ce_i, .mdc_i, .mdio_i, .mdio_o, .mdio_oe_n_o, .wr_pulse_o, .wr_addr_o,
    .wr_data_o);

// File: test/mdio_ctl.sv
// Management controller model that runs frames on the data line
`timescale 1ns/10ps
module mdio_ctl (
    input wire logic md_i,
    output logic mdc_o,
    output logic md_o,
    output logic md_en_o
);
    initial begin
        mdc_o = 1'b0;
        md_o = 1'b1;
        md_en_o = 1'b0;
    end
    // 400 ns bit; long low phase gives the answer time to settle
    task automatic bit_io(input logic d, en, output logic q);
        md_o = d;
        md_en_o = en;
        #250 mdc_o = 1'b1;
        q = md_i;
        #150 mdc_o = 1'b0;
    endtask : bit_io
    // Clock stands low between frames
    task automatic frame(input int npre, input logic [1:0] op,
            input logic [9:0] ad, input logic [15:0] wd,
            output logic [17:0] rd);
        logic q;
        logic [13:0] hdr;
        logic [17:0] dat;
        hdr = {2'b01, op, ad};
        dat = {2'b10, wd};
        rd = 18'h0;
        for (int i = 0; i < npre; i++) bit_io(1'b1, 1'b1, q);
        for (int i = 13; i >= 0; i--) bit_io(hdr[i], 1'b1, q);
        for (int i = 17; i >= 0; i--) begin
            bit_io(dat[i], op == 2'h1, q);
            rd = {rd[16:0], q};
        end
        md_en_o = 1'b0;
        // One idle bit so a following frame never re-drives in this step
        #400;
    endtask : frame
endmodule : mdio_ctl

// File: test/mdio_full_register_access_slave_bench.sv
// Bench for the management access slave
`timescale 1ns/10ps
module mdio_full_register_access_slave_bench;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic mdc, md_c, md_en, mdio_o, oe_n, wr_pulse;
    logic [7:0] wr_addr, wr_data;
    logic [7:0] tbl [9] = '{8'h00, 8'h15, 8'h57, 8'h6e, 8'h6f, 8'h70,
        8'h78, 8'h88, 8'hff};
    // Pull-up holds the line high when nobody drives it
    wire mdio_w = !oe_n ? mdio_o : (md_en ? md_c : 1'b1);
    int n_fail = 0;
    int n_compared = 0;
    int n_pulse = 0;
    always #25 clk_i = ~clk_i;
    always @(posedge clk_i) if (wr_pulse === 1'b1) n_pulse++;
    mgmt_access_slave i_dut (.clk_i, .sys_rst_i, .ce_i(1'b1), .mdc_i(mdc),
        .mdio_i(mdio_w), .mdio_o, .mdio_oe_n_o(oe_n), .wr_pulse_o(wr_pulse),
        .wr_addr_o(wr_addr), .wr_data_o(wr_data));
    mdio_ctl i_ctl (.md_i(mdio_w), .mdc_o(mdc), .md_o(md_c), .md_en_o(md_en));
    task automatic chk(input string what, input logic [16:0] exp, got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask : chk
    task automatic wrap_up;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : wrap_up
    function automatic logic [9:0] fld(input logic [7:0] a);
        return {a[7:6], 2'b11, a[5], a[4:0]};
    endfunction : fld
    // Upper byte is the inverse so a stored high byte would show
    task automatic wr_chk(input logic [7:0] a, d);
        logic [17:0] rd;
        int p;
        p = n_pulse;
        i_ctl.frame(32, 2'h1, fld(a), {~d, d}, rd);
        #200;
        chk("write", {1'b1, a, d}, {n_pulse == p + 1, wr_addr, wr_data});
    endtask : wr_chk
    task automatic rd_chk(input logic [7:0] a, d);
        logic [17:0] rd;
        i_ctl.frame(32, 2'h2, fld(a), 16'h0, rd);
        chk("read", {9'h0, d}, rd[16:0]);
    endtask : rd_chk
    // All writes first, then all reads, so aliased addresses show up
    task automatic t_space;
        foreach (tbl[i]) wr_chk(tbl[i], ~tbl[i]);
        foreach (tbl[i]) rd_chk(tbl[i], ~tbl[i]);
    endtask : t_space
    // Data ends in zeros so no frame tops up the next short preamble
    task automatic t_refused;
        logic [17:0] rd;
        int p;
        p = n_pulse;
        i_ctl.frame(32, 2'h1, 10'h040, 16'hff00, rd);
        i_ctl.frame(32, 2'h3, fld(8'h00), 16'hff00, rd);
        i_ctl.frame(31, 2'h1, fld(8'h00), 16'hff00, rd);
        #200;
        chk("no write", 17'h0, {16'h0, n_pulse != p});
        i_ctl.frame(32, 2'h2, 10'h040, 16'h0, rd);
        chk("no drive", 17'h1ffff, rd[16:0]);
        rd_chk(8'h00, 8'hff);
    endtask : t_refused
    initial begin
        #2000000;
        n_fail++;
        wrap_up();
    end
    initial begin
        repeat (2) @(posedge clk_i);
        @(negedge clk_i) sys_rst_i = 1'b0;
        repeat (3) @(negedge clk_i);
        #13;
        t_space();
        t_refused();
        wrap_up();
    end
endmodule : mdio_full_register_access_slave_bench
